// file: csb_proc_end.sv
// Processor end: bus master cycles, retry and fault handling, bus yield
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Direction high on write, matching strobe
// - Data strobe after address, off at end
// - Read data valid at acknowledge, captured
// - Write acknowledge completes the beat
// - Fault input ends cycle as error
// - Retry terminates current cycle
// - Read ignores retry after first beat
// - Write honours retry every beat
// - Cold reset initialises the device
// - General reset resets in both cases
// - Requester holds request while needing bus
// - Yield on request, reclaim on negation
// - Release indication low two clocks minimum
// - Release high on own need or negation
// - Release pin sampled as strap bit5
// - Cycle active from address to ack
module csb_proc_end
    import csb_pkg::*;
#(
    parameter int unsigned DW    = DATA_WIDTH_DEF,
    parameter int unsigned DEPTH = FIFO_DEPTH_DEF
)
(
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    csb_if.proc                         bus,
    input  wire logic                   reqValid,
    output logic                        reqReady,
    input  wire logic                   reqWrite,
    input  wire logic [DW-1:0]          reqAddr,
    input  wire logic [BEATS_WIDTH-1:0] reqBeats,
    input  wire logic [DW-1:0]          wrData,
    input  wire logic                   wrValid,
    output logic                        wrReady,
    output logic      [DW-1:0]          rdData,
    output logic                        rdValid,
    input  wire logic                   rdReady,
    output logic                        doneOk,
    output logic                        doneFault,
    output logic                        doneRetry,
    output logic                        bootConfigBit5,
    input  wire logic                   ownNeed
);
    // ************************************************************
    // State
    // ************************************************************
    csb_state_e             state_r, state_nxt;   // Master state
    logic                   isWrite_r;            // Current cycle direction
    logic [BEATS_WIDTH-1:0] beatsLeft_r;          // Beats remaining minus one
    logic                   firstDone_r;          // A beat of this cycle was accepted
    logic [1:0]             grantCnt_r;           // Low time of release pin
    logic                   doneOk_r, doneFault_r, doneRetry_r, strap_r;
    logic                   fifoInReady;          // Read buffer space
    logic                   rdCaptured_r;         // Unused; never assigned or read
    // ************************************************************
    // Decode
    // ************************************************************
    wire ack      = !bus.ackN;
    wire fault    = !bus.transfer_fault_n;
    wire retryHit = !bus.retryN && (isWrite_r || !firstDone_r);
    wire lastBeat = (beatsLeft_r == '0);
    wire inData   = (state_r == CSB_DATA);
    wire beatOk   = inData && ack && !fault && !retryHit &&
                    (isWrite_r ? wrValid : fifoInReady);
    wire endCycle = inData && (fault || retryHit || (beatOk && lastBeat));
    wire request  = !bus.mastership_request_n;
    wire grantMin = (grantCnt_r >= 2'(GRANT_MIN_CLKS));
    wire startOk  = reqValid && !request && bus.power_on_reset_n;
    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CSB_IDLE:   if (request) state_nxt = CSB_YIELD;
                        else if (reqValid) state_nxt = CSB_ADDR;
            CSB_ADDR:   state_nxt = CSB_DATA;
            CSB_DATA:   if (endCycle) state_nxt = CSB_IDLE;
            CSB_YIELD:  state_nxt = CSB_PARKED;
            CSB_PARKED: if (grantMin && (!request || ownNeed)) state_nxt = CSB_IDLE;
            default:    state_nxt = CSB_IDLE;
        endcase
        // Cold reset holds the machine in idle, so no cycle starts before the strap settles
        if (!bus.power_on_reset_n)
            state_nxt = CSB_IDLE;
    end
    // ************************************************************
    // Read buffer
    // ************************************************************
    csb_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_rdbuf
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .inData   (bus.laneWire),
        .inValid  (beatOk && !isWrite_r),
        .inReady  (fifoInReady),
        .outData  (rdData),
        .outValid (rdValid),
        .outReady (rdReady)
    );
    assign reqReady = (state_r == CSB_IDLE) && startOk;
    assign wrReady  = beatOk && isWrite_r;
    // State and counters; nrst clears all, cold reset clears state, firstDone_r and grantCnt_r only
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r     <= CSB_IDLE;
            isWrite_r   <= RST_LEVEL_LOW;
            beatsLeft_r <= '0;
            firstDone_r <= RST_LEVEL_LOW;
            grantCnt_r  <= '0;
        end
        else if (!bus.power_on_reset_n)
        begin
            state_r     <= CSB_IDLE;
            firstDone_r <= RST_LEVEL_LOW;
            grantCnt_r  <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            if (reqReady)
            begin
                isWrite_r   <= reqWrite;
                beatsLeft_r <= reqBeats;
                firstDone_r <= RST_LEVEL_LOW;
            end
            else if (beatOk)
            begin
                beatsLeft_r <= beatsLeft_r - BEATS_WIDTH'(1);
                firstDone_r <= RST_LEVEL_HIGH;
            end
            if (state_nxt == CSB_PARKED)
                grantCnt_r <= grantMin ? grantCnt_r : grantCnt_r + 2'(1);
            else
                grantCnt_r <= '0;
        end
    end
    // Completion pulses
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            doneOk_r    <= RST_LEVEL_LOW;
            doneFault_r <= RST_LEVEL_LOW;
            doneRetry_r <= RST_LEVEL_LOW;
        end
        else
        begin
            doneOk_r    <= inData && beatOk && lastBeat && !fault;
            doneFault_r <= inData && fault;
            doneRetry_r <= inData && !fault && retryHit;
        end
    end
    // Strap capture while cold reset is low
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strap_r    <= RST_LEVEL_LOW;
        end
        else
        begin
            if (!bus.power_on_reset_n)
                strap_r <= bus.grantIn;
        end
    end
    // ************************************************************
    // Pin outputs, registered from next state; release enable from cold reset
    // ************************************************************
    logic dir_r, rdN_r, wrN_r, denN_r, cipN_r, lastN_r, gntN_r, gntOe_r, laneOe_r;
    logic [DW-1:0] lane_r;
    wire  nxtBusy   = (state_nxt == CSB_ADDR) || (state_nxt == CSB_DATA);
    wire  nxtWrite  = reqReady ? reqWrite : isWrite_r;
    wire  nxtLeft0  = reqReady ? (reqBeats == '0) :
                      (beatOk ? (beatsLeft_r == BEATS_WIDTH'(1)) : lastBeat);
    wire  nxtParked = (state_nxt == CSB_PARKED) || (state_nxt == CSB_YIELD);
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dir_r    <= RST_LEVEL_LOW;
            rdN_r    <= RST_LEVEL_HIGH;
            wrN_r    <= RST_LEVEL_HIGH;
            denN_r   <= RST_LEVEL_HIGH;
            cipN_r   <= RST_LEVEL_HIGH;
            lastN_r  <= RST_LEVEL_HIGH;
            gntN_r   <= RST_LEVEL_HIGH;
            gntOe_r  <= RST_LEVEL_LOW;
            laneOe_r <= RST_LEVEL_LOW;
            lane_r   <= RST_WORD[DW-1:0];
        end
        else
        begin
            dir_r    <= nxtBusy && nxtWrite;
            rdN_r    <= !(nxtBusy && !nxtWrite);
            wrN_r    <= !(nxtBusy && nxtWrite);
            denN_r   <= !(state_nxt == CSB_DATA);
            cipN_r   <= !nxtBusy;
            lastN_r  <= !((state_nxt == CSB_DATA) && nxtLeft0);
            gntN_r   <= !nxtParked;
            gntOe_r  <= bus.power_on_reset_n;
            laneOe_r <= !nxtParked && (state_nxt == CSB_ADDR ||
                        (state_nxt == CSB_DATA && nxtWrite));
            lane_r   <= (state_nxt == CSB_ADDR) ? reqAddr : wrData;
        end
    end
    assign bus.transfer_direction  = dir_r;
    assign bus.readStrobeN         = rdN_r;
    assign bus.writeStrobeN        = wrN_r;
    assign bus.data_phase_strobe_n = denN_r;
    assign bus.cycle_active_n      = cipN_r;
    assign bus.finalBeatN          = lastN_r;
    assign bus.grantOut            = gntN_r;
    assign bus.grantOe             = gntOe_r;
    assign bus.masterLaneOe        = laneOe_r;
    assign bus.masterLane          = lane_r;
    assign doneOk         = doneOk_r;
    assign doneFault      = doneFault_r;
    assign doneRetry      = doneRetry_r;
    assign bootConfigBit5 = strap_r;
endmodule : csb_proc_end
`default_nettype wire

// file: csb_pkg.sv
// Shared constants and types for the system bus handshake ends
`default_nettype none
package csb_pkg;
    // ************************************************************
    // Timing and sizes
    // ************************************************************
    localparam int unsigned GRANT_MIN_CLKS   = 2;     // Least low time of release indication
    localparam int unsigned CLK_PERIOD_NS    = 5;     // Bus clock period
    localparam int unsigned FIFO_DEPTH_DEF   = 16;    // Words of buffering
    localparam int unsigned DATA_WIDTH_DEF   = 32;    // Bus word width
    localparam int unsigned BEATS_WIDTH      = 3;     // Width of a beat count
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic        RST_LEVEL_HIGH   = 1'h1;  // Idle level of active-low outputs
    localparam logic        RST_LEVEL_LOW    = 1'h0;  // Idle level of active-high outputs
    localparam logic [31:0] RST_WORD         = 32'h00000000;
    // ************************************************************
    // Master state machine
    // ************************************************************
    typedef enum logic [2:0]
    {
        CSB_IDLE,
        CSB_ADDR,
        CSB_DATA,
        CSB_YIELD,
        CSB_PARKED
    } csb_state_e;
endpackage : csb_pkg
`default_nettype wire

// file: csb_if.sv
// Interface joining the processor end and the memory/DMA end
`timescale 1ns/1ps
`default_nettype none
interface csb_if
    import csb_pkg::*;
#(
    parameter int unsigned DW = DATA_WIDTH_DEF
);
    logic          busAddrData;              // Processor drives the lane, copy of masterLaneOe
    logic [DW-1:0] masterLane;               // Value driven by processor
    logic          masterLaneOe;             // Processor drives the lane
    logic [DW-1:0] slaveLane;                // Value driven by memory
    logic          slaveLaneOe;              // Memory drives the lane
    logic          transfer_direction;       // High write, low read
    logic          readStrobeN;              // Read cycle, active low
    logic          writeStrobeN;             // Write cycle, active low
    logic          data_phase_strobe_n;      // Data phase, active low
    logic          cycle_active_n;           // Cycle in progress, active low
    logic          finalBeatN;               // Last beat, active low
    logic          ackN;                     // Acknowledge, active low
    logic          transfer_fault_n;         // Bus error, active low
    logic          retryN;                   // Retry, active low
    logic          mastership_request_n;     // External request, active low
    logic          grantOut;                 // Release pin, processor value
    logic          grantOe;                  // Release pin, processor drives
    logic          grantIn;                  // Release pin as seen on wire
    logic          strapDrive;               // System strap value
    logic          strapOe;                  // System drives strap
    logic          power_on_reset_n;         // Cold reset, active low
    logic [DW-1:0] laneWire;                 // Resolved lane
    // Wire resolution of shared pins
    assign laneWire = masterLaneOe ? masterLane : slaveLane;
    assign grantIn  = grantOe ? grantOut : (strapOe ? strapDrive : RST_LEVEL_HIGH);
    assign busAddrData = masterLaneOe;
    modport proc
    (
        output masterLane, masterLaneOe, transfer_direction, readStrobeN, writeStrobeN,
        output data_phase_strobe_n, cycle_active_n, finalBeatN, grantOut, grantOe,
        input  laneWire, ackN, transfer_fault_n, retryN, mastership_request_n, grantIn,
        input  power_on_reset_n
    );
    modport sys
    (
        output slaveLane, slaveLaneOe, ackN, transfer_fault_n, retryN,
        output mastership_request_n, strapDrive, strapOe, power_on_reset_n,
        input  laneWire, transfer_direction, readStrobeN, writeStrobeN,
        input  data_phase_strobe_n, cycle_active_n, finalBeatN, grantIn
    );
endinterface : csb_if
`default_nettype wire

// file: csb_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module csb_fifo
    import csb_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_WIDTH_DEF,
    parameter int unsigned DEPTH = FIFO_DEPTH_DEF
)
(
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];        // Storage
    logic [AW-1:0]    wrPtr_r;              // Write index
    logic [AW-1:0]    rdPtr_r;              // Read index
    logic [AW:0]      count_r;              // Occupancy
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;
    // Index advance with wrap
    function automatic logic [AW-1:0] nextIdx(input logic [AW-1:0] idx);
        nextIdx = (idx == AW'(DEPTH - 1)) ? '0 : idx + AW'(1);
    endfunction : nextIdx
    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];
    // Pointer and count update
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (doPush)
                wrPtr_r <= nextIdx(wrPtr_r);
            if (doPop)
                rdPtr_r <= nextIdx(rdPtr_r);
            count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
    // Storage write
    always_ff @(posedge ref_clk)
    begin
        if (doPush)
            mem_r[wrPtr_r] <= inData;
    end
endmodule : csb_fifo
`default_nettype wire

// file: csb_sys_end.sv
// System end: memory acknowledge, fault and retry; requester; cold reset and strap
`timescale 1ns/1ps
`default_nettype none
module csb_sys_end
    import csb_pkg::*;
#(
    parameter int unsigned DW = DATA_WIDTH_DEF
)
(
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    csb_if.sys                 bus,
    input  wire logic          memReady,
    input  wire logic          memFault,
    input  wire logic          memRetry,
    input  wire logic [DW-1:0] memRdData,
    output logic      [DW-1:0] memWrData,
    output logic               memWrStrobe,
    input  wire logic          dmaWant,
    output logic               dmaOwned,
    input  wire logic          coldResetReq,
    input  wire logic          strapValue
);
    logic ackN_r, faultN_r, retryN_r, reqN_r, oe_r, cold_r, wrStb_r, owned_r;
    logic [DW-1:0] rd_r, wr_r;
    wire  inData = !bus.data_phase_strobe_n;
    // Answers to the processor's data phase
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ackN_r   <= RST_LEVEL_HIGH;
            faultN_r <= RST_LEVEL_HIGH;
            retryN_r <= RST_LEVEL_HIGH;
            oe_r     <= RST_LEVEL_LOW;
            rd_r     <= RST_WORD[DW-1:0];
            wr_r     <= RST_WORD[DW-1:0];
            wrStb_r  <= RST_LEVEL_LOW;
        end
        else
        begin
            // Ack at most every other cycle, so each beat is taken once
            ackN_r   <= !(inData && memReady && ackN_r);
            faultN_r <= !(inData && memFault);
            retryN_r <= !(inData && memRetry);
            oe_r     <= inData && !bus.transfer_direction;
            rd_r     <= memRdData;
            // Store at the edge where the processor counts the beat
            wrStb_r  <= inData && !ackN_r && retryN_r && faultN_r &&
                        bus.transfer_direction;
            wr_r     <= bus.laneWire;
        end
    end
    // Requester and cold reset drive
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reqN_r  <= RST_LEVEL_HIGH;
            cold_r  <= RST_LEVEL_LOW;
            owned_r <= RST_LEVEL_LOW;
        end
        else
        begin
            reqN_r  <= !dmaWant;
            cold_r  <= !coldResetReq;
            owned_r <= !bus.grantIn && bus.power_on_reset_n;
        end
    end
    assign bus.slaveLane            = rd_r;
    assign bus.slaveLaneOe          = oe_r;
    assign bus.ackN                 = ackN_r;
    assign bus.transfer_fault_n     = faultN_r;
    assign bus.retryN               = retryN_r;
    assign bus.mastership_request_n = reqN_r;
    assign bus.power_on_reset_n     = cold_r;
    assign bus.strapDrive           = strapValue;
    assign bus.strapOe              = !cold_r;
    assign memWrData   = wr_r;
    assign memWrStrobe = wrStb_r;
    assign dmaOwned    = owned_r;
endmodule : csb_sys_end
`default_nettype wire

// file: csb_bus_sva.sv
// Concurrent checks on the wires between the two bus ends
`timescale 1ns/1ps
`default_nettype none
module csb_bus_sva
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic power_on_reset_n,
    input wire logic transfer_direction,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic data_phase_strobe_n,
    input wire logic cycle_active_n,
    input wire logic finalBeatN,
    input wire logic transfer_fault_n,
    input wire logic retryN,
    input wire logic mastership_request_n,
    input wire logic grantOut,
    input wire logic grantOe,
    input wire logic masterLaneOe
);
    // Release pin driven low by the processor end
    wire relLow = grantOe & ~grantOut;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst || !power_on_reset_n);
    // ************************************************************
    // Cycle steps
    // ************************************************************
    sequence s_start; $fell(cycle_active_n); endsequence
    sequence s_data; !data_phase_strobe_n; endsequence
    property p_dir;
        !readStrobeN || !writeStrobeN |-> transfer_direction == readStrobeN;
    endproperty
    property p_onehot; s_start |-> readStrobeN != writeStrobeN; endproperty
    property p_den; s_start |=> s_data; endproperty
    property p_cip; s_data |-> !cycle_active_n; endproperty
    property p_hold;
        !cycle_active_n && finalBeatN && transfer_fault_n && retryN |=> !cycle_active_n;
    endproperty
    property p_fin; !finalBeatN |-> s_data; endproperty
    property p_min; $rose(relLow) |=> relLow; endproperty
    property p_off; relLow |-> cycle_active_n && !masterLaneOe; endproperty
    property p_back; $rose(mastership_request_n) && relLow |-> ##[0:4] !relLow; endproperty
    property p_strap;
        disable iff (!nrst) !$past(power_on_reset_n) && !power_on_reset_n |-> !grantOe;
    endproperty
    a_dir: assert property (p_dir) else $error("direction disagrees with strobe");
    a_onehot: assert property (p_onehot) else $error("strobes not one-hot");
    a_den: assert property (p_den) else $error("data strobe late");
    a_cip: assert property (p_cip) else $error("data phase outside cycle");
    a_hold: assert property (p_hold) else $error("cycle dropped early");
    a_fin: assert property (p_fin) else $error("final beat outside data");
    a_min: assert property (p_min) else $error("release too short");
    a_off: assert property (p_off) else $error("bus driven while released");
    a_back: assert property (p_back) else $error("bus not reclaimed");
    a_strap: assert property (p_strap) else $error("release driven in cold reset");
endmodule : csb_bus_sva
`default_nettype wire

// file: tb_cpu_system_bus_handshake.sv
// Self-checking bench joining both bus ends through the shared interface
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_system_bus_handshake
    import csb_pkg::*;
;
    logic ref_clk, nrst, reqValid, reqWrite, wrValid, rdReady, ownNeed, memReady, memFault;
    logic memRetry, dmaWant, coldResetReq, strapValue, reqReady, wrReady, rdValid, doneOk;
    logic doneFault, doneRetry, bootBit5, memWrStrobe, dmaOwned;
    logic [31:0] reqAddr, wrData, memRdData, rdData, memWrData, base;
    logic [2:0] reqBeats;
    logic [31:0] wq[$];
    int errors, tests_run;
    csb_if i_csb_if ();
    csb_proc_end i_csb_proc_end (.ref_clk(ref_clk), .nrst(nrst), .bus(i_csb_if),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqBeats(reqBeats), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
        .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady), .doneOk(doneOk),
        .doneFault(doneFault), .doneRetry(doneRetry),
        .bootConfigBit5(bootBit5), .ownNeed(ownNeed));
    csb_sys_end i_csb_sys_end (.ref_clk(ref_clk), .nrst(nrst), .bus(i_csb_if),
        .memReady(memReady), .memFault(memFault), .memRetry(memRetry), .memRdData(memRdData),
        .memWrData(memWrData), .memWrStrobe(memWrStrobe), .dmaWant(dmaWant),
        .dmaOwned(dmaOwned), .coldResetReq(coldResetReq), .strapValue(strapValue));
    csb_bus_sva i_csb_bus_sva (.ref_clk(ref_clk), .nrst(nrst),
        .power_on_reset_n(i_csb_if.power_on_reset_n),
        .transfer_direction(i_csb_if.transfer_direction),
        .readStrobeN(i_csb_if.readStrobeN), .writeStrobeN(i_csb_if.writeStrobeN),
        .data_phase_strobe_n(i_csb_if.data_phase_strobe_n),
        .cycle_active_n(i_csb_if.cycle_active_n),
        .finalBeatN(i_csb_if.finalBeatN), .transfer_fault_n(i_csb_if.transfer_fault_n),
        .retryN(i_csb_if.retryN), .mastership_request_n(i_csb_if.mastership_request_n),
        .grantOut(i_csb_if.grantOut), .grantOe(i_csb_if.grantOe),
        .masterLaneOe(i_csb_if.masterLaneOe));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Next write word once a beat consumes it; record words reaching memory
    always @(posedge ref_clk) if (wrValid && wrReady) wrData <= wrData + 32'h1;
    always @(posedge ref_clk) if (memWrStrobe === 1'b1) wq.push_back(memWrData);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin errors++; $display("BAD %s expected %h seen %h", nm, e, g); end
    endtask : chk
    task automatic await(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 200) begin @(negedge ref_clk); n++; end
        chk("await", v, s);
    endtask : await
    task automatic issue(input logic w, input logic [2:0] b);
        reqWrite = w; reqBeats = b; reqAddr = 32'h00001000; reqValid = 1'b1;
        #1;
        await(reqReady, 1'b1);
        @(negedge ref_clk);
        reqValid = 1'b0;
        chk("dir", w, i_csb_if.transfer_direction);
        chk("rdN", w, i_csb_if.readStrobeN);
        chk("wrN", !w, i_csb_if.writeStrobeN);
    endtask : issue
    task automatic wait_done(input logic [2:0] e);
        int n;
        n = 0;
        do begin @(negedge ref_clk); n++; end
        while ({doneFault, doneRetry, doneOk} === 3'h0 && n < 300);
        chk("done", e, {doneFault, doneRetry, doneOk});
    endtask : wait_done
    task automatic drain(input int k, input logic [31:0] e);
        rdReady = 1'b1;
        repeat (k)
        begin
            #1;
            chk("rdv", 1, rdValid);
            chk("rdd", e, rdData);
            @(negedge ref_clk);
        end
        rdReady = 1'b0;
    endtask : drain
    task automatic sc_cold();
        coldResetReq = 1'b1; strapValue = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("strap0", 0, bootBit5);
        strapValue = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("strap1", 1, bootBit5);
        coldResetReq = 1'b0;
        @(negedge ref_clk);
        strapValue = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("held", 1, bootBit5);
        issue(1'b0, 3'h0);
        nrst = 1'b0;
        @(negedge ref_clk);
        chk("cipRst", 1, i_csb_if.cycle_active_n);
        nrst = 1'b1; memReady = 1'b1;
    endtask : sc_cold
    task automatic sc_fill();
        memRdData = 32'hA5A50001; issue(1'b0, 3'h7); wait_done(3'h1);
        memRdData = 32'h5A5A0002; issue(1'b0, 3'h7); wait_done(3'h1);
        drain(8, 32'hA5A50001);
        drain(8, 32'h5A5A0002);
        #1; chk("empty", 0, rdValid);
    endtask : sc_fill
    task automatic sc_write();
        base = wrData; wq.delete();
        issue(1'b1, 3'h2);
        @(negedge ref_clk);
        chk("lastN", 1, i_csb_if.finalBeatN);
        wait_done(3'h1);
        @(negedge ref_clk);
        chk("nw", 3, wq.size());
        foreach (wq[i]) chk("wd", base + i, wq[i]);
    endtask : sc_write
    task automatic sc_retry(input logic w, input logic [2:0] e);
        issue(w, 3'h3);
        await(i_csb_if.ackN, 1'b0);
        @(negedge ref_clk);
        memRetry = 1'b1; wait_done(e); memRetry = 1'b0;
        if (!w) drain(4, memRdData);
    endtask : sc_retry
    task automatic sc_term();
        memReady = 1'b0; memRetry = 1'b1;
        issue(1'b0, 3'h0);
        @(negedge ref_clk);
        chk("lastN0", 0, i_csb_if.finalBeatN);
        wait_done(3'h2);
        memFault = 1'b1;
        issue(1'b1, 3'h0); wait_done(3'h4);
        memRetry = 1'b0; memFault = 1'b0; memReady = 1'b1;
    endtask : sc_term
    task automatic sc_dma();
        dmaWant = 1'b1; await(dmaOwned, 1'b1);
        chk("gnt", 0, i_csb_if.grantIn);
        reqWrite = 1'b0; reqBeats = 3'h0; reqValid = 1'b1;
        repeat (6) begin @(negedge ref_clk); chk("held", 0, reqReady); end
        dmaWant = 1'b0; issue(1'b0, 3'h0); wait_done(3'h1);
        drain(1, memRdData);
        dmaWant = 1'b1; await(dmaOwned, 1'b1);
        ownNeed = 1'b1; await(i_csb_if.grantIn, 1'b1);
        ownNeed = 1'b0; dmaWant = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk("gntIdle", 1, i_csb_if.grantIn);
    endtask : sc_dma
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        nrst = 1'b0; reqValid = 1'b0; reqWrite = 1'b0; reqAddr = 32'h0; reqBeats = 3'h0;
        wrData = 32'h00000100; wrValid = 1'b1; rdReady = 1'b0; ownNeed = 1'b0; memReady = 1'b0;
        memFault = 1'b0; memRetry = 1'b0; memRdData = 32'h0; dmaWant = 1'b0;
        coldResetReq = 1'b0; strapValue = 1'b0; errors = 0; tests_run = 0;
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        sc_cold(); sc_fill(); sc_write(); sc_retry(1'b0, 3'h1); sc_retry(1'b1, 3'h2);
        sc_term(); sc_dma();
        tally_and_finish();
    end
    initial
    begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : tb_cpu_system_bus_handshake
`default_nettype wire
